// ==== src/ivm_pkg.sv ====
// Package with vector map constants for the interrupt vector dispatch block
package ivm_pkg;
    localparam int NUM_IRQ        = 25;
    localparam int PC_WIDTH       = 14;
    localparam int VEC_IDX_WIDTH  = 5;
    localparam logic [13:0] RESET_ADDR       = 14'h0000;
    localparam logic [13:0] APP_TABLE_BASE   = 14'h0000;
    localparam logic [13:0] BOOT_START_RESET = 14'h0000;
    localparam logic [4:0]  VEC_RESET        = 5'h01;
    localparam logic [4:0]  VEC_EXT_ZERO     = 5'h02;
    localparam logic [4:0]  VEC_WATCHDOG     = 5'h07;
    localparam logic [4:0]  VEC_PROG_STORE   = 5'h1a;
    localparam logic [4:0]  NO_VEC           = 5'h00;
    typedef enum logic [1:0] {
        IVM_VARIANT_SMALL,
        IVM_VARIANT_MID,
        IVM_VARIANT_LARGE
    } ivm_variant_type;
    typedef enum {
        IVM_IDLE,
        IVM_RESET_FETCH,
        IVM_IRQ_FETCH
    } ivm_state_type;
endpackage

// ==== src/ivm_vector_map.sv ====
// Reset and interrupt vector address generator for the processor core
// Summary of operation
// - Any reset vectors to vector one, address zero or boot start if fuse programmed
// - Entry spacing two words large, else one
// - Smallest variant ignores boot fuse and select
// - Larger variants: reset address follows boot fuse
// - Larger variants: table base follows select bit
// - External and pin change requests vectors 2-6
// - Watchdog timeout goes to vector seven
// - Second 8-bit timer sources vectors 8-10
// - Wide timer sources vectors 11-14
// - First 8-bit timer sources vectors 15-17
// - Serial and USART sources vectors 18-21
// - Converter, eeprom, comparator, two-wire, store: 22-26
// - Select bit moves table to boot start
// - Programmed boot fuse starts at boot address
`timescale 1ns/1ps
module ivm_vector_map #(
    parameter ivm_pkg::ivm_variant_type VARIANT    = ivm_pkg::IVM_VARIANT_LARGE,
    parameter logic [13:0]              BOOT_START = 14'h1c00
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  boot_reset_select_fuse_n,
    input  wire logic                  vector_table_select,
    input  wire logic [24:0]           irq_pending,
    input  wire logic                  irq_global_enable,
    input  wire logic                  fetch_ready,
    output logic                       fetch_valid,
    output logic [13:0]                fetch_addr,
    output logic [4:0]                 fetch_vector,
    output logic                       irq_ack
);
    ivm_pkg::ivm_state_type state;
    logic                   fuse_prog;
    logic                   large_map;
    logic [13:0]            table_base;
    logic [13:0]            reset_target;
    logic [4:0]             win_vec;
    logic                   any_irq;

    // Lowest set request bit gives the vector number
    function automatic logic [4:0] pick_vector(input logic [24:0] req);
        logic [4:0] v;
        v = ivm_pkg::NO_VEC;
        for (int i = 24; i >= 0; i--) begin
            if (req[i]) begin
                v = 5'(i + 2);
            end
        end
        return v;
    endfunction

    // Fetch address of one vector entry
    function automatic logic [13:0] vec_addr(input logic [13:0] base, input logic [4:0] vec,
                                             input logic two_words);
        logic [13:0] off;
        off = 14'(vec - 5'h01);
        return two_words ? base + (off << 1) : base + off;
    endfunction

    assign large_map = (VARIANT == ivm_pkg::IVM_VARIANT_LARGE);
    assign fuse_prog = (VARIANT != ivm_pkg::IVM_VARIANT_SMALL) && !boot_reset_select_fuse_n;
    assign reset_target = fuse_prog ? BOOT_START : ivm_pkg::RESET_ADDR;
    assign table_base = ((VARIANT != ivm_pkg::IVM_VARIANT_SMALL) && vector_table_select) ?
                        BOOT_START : ivm_pkg::APP_TABLE_BASE;
    assign win_vec = pick_vector(irq_pending);
    assign any_irq = irq_global_enable && (win_vec != ivm_pkg::NO_VEC);
    assign irq_ack = (state == ivm_pkg::IVM_IRQ_FETCH) && fetch_ready;

    // Vector fetch sequencing
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ivm_pkg::IVM_RESET_FETCH;
        end else begin
            case (state)
                ivm_pkg::IVM_RESET_FETCH: begin
                    if (fetch_ready) begin
                        state <= ivm_pkg::IVM_IDLE;
                    end
                end
                ivm_pkg::IVM_IDLE: begin
                    if (any_irq) begin
                        state <= ivm_pkg::IVM_IRQ_FETCH;
                    end
                end
                ivm_pkg::IVM_IRQ_FETCH: begin
                    if (fetch_ready) begin
                        state <= ivm_pkg::IVM_IDLE;
                    end
                end
                default: state <= ivm_pkg::IVM_IDLE;
            endcase
        end
    end

    // Address and vector number held for the core
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr   <= ivm_pkg::RESET_ADDR;
            fetch_vector <= ivm_pkg::VEC_RESET;
            fetch_valid  <= 1'b1;
        end else begin
            case (state)
                ivm_pkg::IVM_RESET_FETCH: begin
                    fetch_addr   <= reset_target;
                    fetch_vector <= ivm_pkg::VEC_RESET;
                    fetch_valid  <= !fetch_ready;
                end
                ivm_pkg::IVM_IDLE: begin
                    fetch_valid <= any_irq;
                    if (any_irq) begin
                        fetch_addr   <= vec_addr(table_base, win_vec, large_map);
                        fetch_vector <= win_vec;
                    end
                end
                ivm_pkg::IVM_IRQ_FETCH: begin
                    fetch_valid <= !fetch_ready;
                end
                default: fetch_valid <= 1'b0;
            endcase
        end
    end

    wire logic [13:0] step = large_map ? 14'h0002 : 14'h0001;

    reset_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == ivm_pkg::IVM_RESET_FETCH) && $past(rst_n)
        |-> fetch_addr == reset_target && fetch_vector == ivm_pkg::VEC_RESET)
        else $error("reset fetch address wrong");
    reset_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == ivm_pkg::IVM_RESET_FETCH |-> fetch_vector == ivm_pkg::VEC_RESET && !irq_ack)
        else $error("reset fetch vector wrong");
    irq_spacing_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == ivm_pkg::IVM_IDLE && any_irq) |=>
        fetch_addr == $past(table_base) + 14'($past(win_vec) - 5'h01) * $past(step))
        else $error("vector entry spacing wrong");
    small_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (VARIANT != ivm_pkg::IVM_VARIANT_LARGE && state == ivm_pkg::IVM_IDLE && any_irq) |=>
        fetch_addr == $past(table_base) + 14'($past(win_vec) - 5'h01))
        else $error("one word spacing wrong");
    small_fixed_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (VARIANT == ivm_pkg::IVM_VARIANT_SMALL) |-> table_base == ivm_pkg::APP_TABLE_BASE
        && reset_target == ivm_pkg::RESET_ADDR)
        else $error("small variant moved vectors");
    small_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (VARIANT == ivm_pkg::IVM_VARIANT_SMALL && state == ivm_pkg::IVM_RESET_FETCH
        && $past(rst_n)) |-> fetch_addr == ivm_pkg::RESET_ADDR)
        else $error("small variant reset address wrong");
    boot_fuse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (VARIANT != ivm_pkg::IVM_VARIANT_SMALL && !boot_reset_select_fuse_n)
        |-> reset_target == BOOT_START)
        else $error("boot fuse ignored");
    table_move_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (VARIANT != ivm_pkg::IVM_VARIANT_SMALL) |->
        table_base == (vector_table_select ? BOOT_START : ivm_pkg::APP_TABLE_BASE))
        else $error("table base wrong");
    ext_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending[0] |-> win_vec == ivm_pkg::VEC_EXT_ZERO)
        else $error("external request vector wrong");
    ext_one_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending[1:0] == 2'h2 |-> win_vec == 5'h03)
        else $error("second external request vector wrong");
    pin_chg_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending[4:0] == 5'h10 |-> win_vec == 5'h06)
        else $error("pin change vector wrong");
    watchdog_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending[5] && irq_pending[4:0] == 5'h00 |-> win_vec == ivm_pkg::VEC_WATCHDOG)
        else $error("watchdog vector wrong");
    tmr2_cmp_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending[6:0] == 7'h40 |-> win_vec == 5'h08)
        else $error("second timer compare vector wrong");
    tmr2_ovf_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending[8:0] == 9'h100 |-> win_vec == 5'h0a)
        else $error("second timer overflow vector wrong");
    capture_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending[9:0] == 10'h200 |-> win_vec == 5'h0b)
        else $error("capture vector wrong");
    wide_ovf_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending[12:0] == 13'h1000 |-> win_vec == 5'h0e)
        else $error("wide timer overflow vector wrong");
    tmr0_cmp_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending[13:0] == 14'h2000 |-> win_vec == 5'h0f)
        else $error("first timer compare vector wrong");
    tmr0_ovf_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending[15:0] == 16'h8000 |-> win_vec == 5'h11)
        else $error("first timer overflow vector wrong");
    serial_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending[16:0] == 17'h10000 |-> win_vec == 5'h12)
        else $error("serial transfer vector wrong");
    usart_tx_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending[19:0] == 20'h80000 |-> win_vec == 5'h15)
        else $error("transmit complete vector wrong");
    conv_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending[20:0] == 21'h100000 |-> win_vec == 5'h16)
        else $error("conversion vector wrong");
    store_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_pending == 25'h1000000 |-> win_vec == ivm_pkg::VEC_PROG_STORE)
        else $error("program store vector wrong");
    boot_table_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (VARIANT != ivm_pkg::IVM_VARIANT_SMALL && vector_table_select
        && state == ivm_pkg::IVM_IDLE && any_irq) |=>
        fetch_addr == BOOT_START + 14'($past(win_vec) - 5'h01) * $past(step))
        else $error("relocated vector address wrong");
    boot_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (VARIANT != ivm_pkg::IVM_VARIANT_SMALL && !boot_reset_select_fuse_n
        && state == ivm_pkg::IVM_RESET_FETCH && $past(rst_n)) |-> fetch_addr == BOOT_START)
        else $error("boot reset address wrong");
    hold_req_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fetch_valid && !fetch_ready && $past(rst_n) |=> fetch_valid && $stable(fetch_addr))
        else $error("fetch request dropped");
    lowest_first_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == ivm_pkg::IVM_IDLE && irq_global_enable && irq_pending[0] |=>
        fetch_valid && fetch_vector == ivm_pkg::VEC_EXT_ZERO)
        else $error("lowest request not served first");
    masked_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == ivm_pkg::IVM_IDLE && !irq_global_enable |=> !fetch_valid)
        else $error("dispatch while disabled");
    ack_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_ack |=> !fetch_valid && state == ivm_pkg::IVM_IDLE)
        else $error("fetch not released after accept");
    ack_valid_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_ack |-> fetch_valid && fetch_vector != ivm_pkg::VEC_RESET)
        else $error("accept without interrupt fetch");

    reset_fetch_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state == ivm_pkg::IVM_RESET_FETCH && fetch_ready);
    irq_fetch_c: cover property (@(posedge clk_sys) disable iff (!rst_n) irq_ack);
    multi_irq_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        any_irq && $countones(irq_pending) > 1);
    moved_table_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        irq_ack && vector_table_select);
endmodule

// ==== verif/ivm_core_model.sv ====
// Core fetch model: accepts vector fetches after a set stall
`timescale 1ns/1ps
module ivm_core_model (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        fetch_valid,
    input  wire logic [13:0] fetch_addr,
    input  wire logic [4:0]  fetch_vector,
    input  wire logic        irq_ack,
    input  wire logic [3:0]  stall,
    output logic             fetch_ready,
    output logic             got,
    output logic [13:0]      got_addr,
    output logic [4:0]       got_vec,
    output logic             got_ack
);
    logic [3:0] wait_cnt;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fetch_ready <= 1'b0;
            wait_cnt    <= 4'h0;
            got         <= 1'b0;
        end else begin
            got <= 1'b0;
            if (fetch_valid && fetch_ready) begin
                fetch_ready <= 1'b0;
                wait_cnt    <= 4'h0;
                got         <= 1'b1;
                got_addr    <= fetch_addr;
                got_vec     <= fetch_vector;
                got_ack     <= irq_ack;
            end else if (fetch_valid && wait_cnt >= stall) begin
                fetch_ready <= 1'b1;
            end else if (fetch_valid) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule

// ==== verif/ivm_vector_map_bench.sv ====
// Bench for the vector map against the core fetch model
`timescale 1ns/1ps
module ivm_vector_map_bench;
    localparam logic [13:0] BOOT = 14'h1c00;
    logic        clk_sys, rst_n, fuse_n, sel, gie, ready, valid, ack, got, got_ack;
    logic [24:0] pend;
    logic [13:0] addr, got_addr;
    logic [4:0]  vec, got_vec;
    logic [3:0]  stall;
    logic        valid_s, ready_s, ack_s, got_s, got_ack_s;
    logic [13:0] addr_s, got_addr_s;
    logic [4:0]  vec_s, got_vec_s;
    int          miscompares, n_compared;
    int          cycles = 0;
    ivm_vector_map #(.BOOT_START(BOOT)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .boot_reset_select_fuse_n(fuse_n), .vector_table_select(sel), .irq_pending(pend),
        .irq_global_enable(gie), .fetch_ready(ready), .fetch_valid(valid),
        .fetch_addr(addr), .fetch_vector(vec), .irq_ack(ack));
    ivm_core_model i_core (.clk_sys(clk_sys), .rst_n(rst_n), .fetch_valid(valid),
        .fetch_addr(addr), .fetch_vector(vec), .irq_ack(ack), .stall(stall),
        .fetch_ready(ready), .got(got), .got_addr(got_addr), .got_vec(got_vec),
        .got_ack(got_ack));
    ivm_vector_map #(.VARIANT(ivm_pkg::IVM_VARIANT_SMALL), .BOOT_START(BOOT)) i_dut_small (
        .clk_sys(clk_sys), .rst_n(rst_n), .boot_reset_select_fuse_n(fuse_n),
        .vector_table_select(sel), .irq_pending(pend), .irq_global_enable(gie),
        .fetch_ready(ready_s), .fetch_valid(valid_s), .fetch_addr(addr_s),
        .fetch_vector(vec_s), .irq_ack(ack_s));
    ivm_core_model i_core_small (.clk_sys(clk_sys), .rst_n(rst_n), .fetch_valid(valid_s),
        .fetch_addr(addr_s), .fetch_vector(vec_s), .irq_ack(ack_s), .stall(stall),
        .fetch_ready(ready_s), .got(got_s), .got_addr(got_addr_s), .got_vec(got_vec_s),
        .got_ack(got_ack_s));
    task automatic check(input logic [13:0] act, input logic [13:0] exp);
        n_compared++;
        if (act !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d, wrong %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic fetch(input logic [4:0] v, input logic [13:0] a, input logic k);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (got !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        pend = 25'h0;
        check({13'h0, got}, 14'h1);
        check({9'h0, got_vec}, {9'h0, v});
        check(got_addr, a);
        check({13'h0, got_ack}, {13'h0, k});
        check({13'h0, got_s}, 14'h1);
        check({9'h0, got_vec_s}, {9'h0, v});
        check(got_addr_s, 14'(v - 5'h01));
        check({13'h0, got_ack_s}, {13'h0, k});
    endtask
    task automatic sweep(input logic s, input logic [3:0] st);
        for (int i = 0; i < 25; i++) begin
            @(negedge clk_sys);
            sel = s;
            stall = st;
            pend = 25'h1 << i;
            fetch(5'(i + 2), (s ? BOOT : 14'h0) + 14'(2 * (i + 1)), 1'b1);
        end
    endtask
    task automatic lowest_wins();
        @(negedge clk_sys);
        sel = 1'b0;
        pend = 25'h1000208;
        fetch(5'h05, 14'h0008, 1'b1);
    endtask
    task automatic masked();
        @(negedge clk_sys);
        gie = 1'b0;
        pend = 25'h0000001;
        repeat (6) @(negedge clk_sys);
        check({13'h0, valid}, 14'h0);
        check({13'h0, valid_s}, 14'h0);
        gie = 1'b1;
        fetch(5'h02, 14'h0002, 1'b1);
    endtask
    task automatic do_reset(input logic f, input logic [13:0] a);
        @(negedge clk_sys);
        rst_n = 1'b0;
        fuse_n = f;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        fetch(5'h01, a, 1'b0);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 4000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        {rst_n, fuse_n, sel, gie, pend, stall} = {1'b0, 1'b1, 1'b0, 1'b1, 25'h0, 4'h0};
        miscompares = 0;
        n_compared = 0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        fetch(5'h01, 14'h0000, 1'b0);
        sweep(1'b0, 4'h0);
        sweep(1'b1, 4'h3);
        lowest_wins();
        masked();
        do_reset(1'b0, BOOT);
        print_verdict();
    end
endmodule
